// *** hdl/tof_cfg_pkg.sv ***
package tof_cfg_pkg;

  localparam logic [7:0] ADDR_PHASE_SAMPLE = 8'h92;
  localparam logic [7:0] ADDR_READOUT = 8'h95;
  localparam logic [7:0] ADDR_MULT_HIGH = 8'hA0;
  localparam logic [7:0] ADDR_MULT_LOW = 8'hA1;
  localparam logic [7:0] ADDR_LEN_HIGH = 8'hA2;
  localparam logic [7:0] ADDR_LEN_LOW = 8'hA3;
  localparam logic [7:0] ADDR_DELAY_CTRL = 8'hAE;
  localparam logic [7:0] ADDR_TEMP_OFFSET = 8'hD9;
  localparam logic [7:0] ADDR_DELAY_STEP = 8'hDA;

  localparam logic [7:0] RST_PHASE_SAMPLE = 8'h30;
  localparam logic [7:0] RST_READOUT = 8'h23;
  localparam logic [7:0] RST_MULT_HIGH = 8'h00;
  localparam logic [7:0] RST_MULT_LOW = 8'h01;
  localparam logic [7:0] RST_LEN_HIGH = 8'h00;
  localparam logic [7:0] RST_LEN_LOW = 8'h01;
  localparam logic [7:0] RST_DELAY_CTRL = 8'h01;
  localparam logic [7:0] RST_TEMP_OFFSET = 8'hFF;
  localparam logic [7:0] RST_DELAY_STEP = 8'hFF;

  // phase sample register fields
  localparam int SAMPLE_COUNT_LSB = 4;
  localparam int MOD_MODE_LSB = 6;
  localparam int INT_SEL_LSB = 2;
  // readout register fields
  localparam int PIXEL_MODE_LSB = 2;
  localparam int FORMAT_BIT = 5;
  localparam int RAW_BIT = 6;

  localparam logic [7:0] DELAY_OFF = 8'h01;
  localparam logic [7:0] DELAY_MANUAL = 8'h04;
  localparam logic [7:0] NOT_SUPPORTED = 8'hFF;
  localparam logic [7:0] TEMP_ZERO = 8'h7F;
  localparam logic [7:0] STEP_CENTER = 8'h80;
  // step figures in picoseconds
  localparam int STEP_UNIT_PS = 3;
  localparam int STEP_BASE_PS = 2100;

  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    SAMPLES_ONE, SAMPLES_TWO, SAMPLES_FOUR, SAMPLES_BAD
  } sample_count_type;

  typedef enum logic [1:0] {
    MOD_DISTANCE, MOD_GRAY, MOD_BAD
  } mod_mode_type;

  typedef enum logic [2:0] {
    full_imager_distance_mode, full_imager_gray_mode, all_pixel_sum_mode,
    center_four_sum_mode, row_sum_mode, binned_gray_mode, PIXEL_BAD
  } pixel_mode_type;

  typedef struct packed {
    sample_count_type sample_count;
    mod_mode_type mod_mode;
    pixel_mode_type pixel_mode;
    logic signed_format;
    logic flags_embedded;
    logic per_row_integration;
    logic int_sel_bad;
    logic [9:0] multiplier;
    logic [15:0] length;
    logic delay_enable;
    logic delay_bad;
    logic temp_supported;
    logic signed [8:0] temp_offset_steps;
    logic step_supported;
    logic signed [15:0] step_ps;
  } acq_config_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_cmd_type;

endpackage

// *** hdl/tof_cfg_decode.sv ***
`timescale 1ns/1ps
module tof_cfg_decode
  import tof_cfg_pkg::*;
(
  input wire logic [7:0] phase_reg_in,
  input wire logic [7:0] readout_reg_in,
  input wire logic [7:0] mult_high_in,
  input wire logic [7:0] mult_low_in,
  input wire logic [7:0] len_high_in,
  input wire logic [7:0] len_low_in,
  input wire logic [7:0] delay_ctrl_in,
  input wire logic [7:0] temp_reg_in,
  input wire logic [7:0] step_reg_in,
  output acq_config_type cfg_out
);
  wire logic [1:0] count_code = phase_reg_in[SAMPLE_COUNT_LSB +: 2];
  wire logic [1:0] mod_code = phase_reg_in[MOD_MODE_LSB +: 2];
  wire logic [1:0] int_code = phase_reg_in[INT_SEL_LSB +: 2];
  wire logic [2:0] pix_code = readout_reg_in[PIXEL_MODE_LSB +: 3];
  wire mod_mode_type mod_mode;
  wire pixel_mode_type pixel_mode;
  wire sample_count_type sample_count;
  wire logic signed [15:0] step_diff;

  assign sample_count = (count_code == 2'h0) ? SAMPLES_ONE :
                        (count_code == 2'h1) ? SAMPLES_TWO :
                        (count_code == 2'h3) ? SAMPLES_FOUR : SAMPLES_BAD;
  assign mod_mode = (mod_code == 2'h0) ? MOD_DISTANCE :
                    (mod_code == 2'h3) ? MOD_GRAY : MOD_BAD;
  assign pixel_mode = (pix_code == 3'h0) ?
                        ((mod_mode == MOD_GRAY) ? full_imager_gray_mode : full_imager_distance_mode) :
                      (pix_code == 3'h1) ? all_pixel_sum_mode :
                      (pix_code == 3'h2) ? center_four_sum_mode :
                      (pix_code == 3'h3) ? row_sum_mode :
                      (pix_code == 3'h5) ? binned_gray_mode : PIXEL_BAD;
  assign step_diff = 16'(signed'({8'h00, step_reg_in}) - signed'({8'h00, STEP_CENTER}));

  assign cfg_out.sample_count = sample_count;
  assign cfg_out.mod_mode = mod_mode;
  assign cfg_out.pixel_mode = pixel_mode;
  assign cfg_out.signed_format = readout_reg_in[FORMAT_BIT];
  assign cfg_out.flags_embedded = ~readout_reg_in[RAW_BIT];
  assign cfg_out.per_row_integration = (int_code == 2'h2);
  assign cfg_out.int_sel_bad = (int_code == 2'h1) || (int_code == 2'h3);
  assign cfg_out.multiplier = {mult_high_in[1:0], mult_low_in};
  assign cfg_out.length = {len_high_in, len_low_in};
  assign cfg_out.delay_enable = (delay_ctrl_in == DELAY_MANUAL);
  assign cfg_out.delay_bad = (delay_ctrl_in != DELAY_MANUAL) && (delay_ctrl_in != DELAY_OFF);
  assign cfg_out.temp_supported = (temp_reg_in != NOT_SUPPORTED);
  assign cfg_out.temp_offset_steps = 9'(signed'({1'b0, temp_reg_in}) - signed'({1'b0, TEMP_ZERO}));
  assign cfg_out.step_supported = (step_reg_in != NOT_SUPPORTED);
  assign cfg_out.step_ps = 16'(step_diff * 16'(STEP_UNIT_PS) + 16'(STEP_BASE_PS));
endmodule

// *** hdl/tof_acquisition_config_regs.sv ***
`timescale 1ns/1ps
module tof_acquisition_config_regs
  import tof_cfg_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  input wire logic FRAME_START_IN,
  input wire logic MOD_TICK_IN,
  output acq_config_type CFG_OUT,
  output logic INTEGRATING_OUT,
  output logic INTEGRATION_DONE_OUT
);
  logic [7:0] phase_reg;
  logic [7:0] readout_reg;
  logic [7:0] mult_high;
  logic [7:0] mult_low;
  logic [7:0] len_high;
  logic [7:0] len_low;
  logic [7:0] delay_ctrl;
  logic [7:0] temp_reg;
  logic [7:0] step_reg;
  acq_config_type shadow_cfg;
  acq_config_type active_cfg;
  logic [15:0] period_count;
  logic [9:0] repeat_count;
  logic integrating;
  logic done;
  reg_cmd_type cmd;

  assign cmd.wr = REG_WR_IN;
  assign cmd.rd = REG_RD_IN;
  assign cmd.addr = REG_ADDR_IN;
  assign cmd.wdata = REG_WDATA_IN;

  function automatic logic hit(input reg_cmd_type c, input logic [7:0] a);
    hit = c.wr && (c.addr == a);
  endfunction

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      phase_reg <= RST_PHASE_SAMPLE;
      readout_reg <= RST_READOUT;
      mult_high <= RST_MULT_HIGH;
      mult_low <= RST_MULT_LOW;
      len_high <= RST_LEN_HIGH;
      len_low <= RST_LEN_LOW;
      delay_ctrl <= RST_DELAY_CTRL;
      temp_reg <= RST_TEMP_OFFSET;
      step_reg <= RST_DELAY_STEP;
    end else begin
      if (hit(cmd, ADDR_PHASE_SAMPLE)) phase_reg <= cmd.wdata;
      if (hit(cmd, ADDR_READOUT)) readout_reg <= cmd.wdata;
      if (hit(cmd, ADDR_MULT_HIGH)) mult_high <= cmd.wdata;
      if (hit(cmd, ADDR_MULT_LOW)) mult_low <= cmd.wdata;
      if (hit(cmd, ADDR_LEN_HIGH)) len_high <= cmd.wdata;
      if (hit(cmd, ADDR_LEN_LOW)) len_low <= cmd.wdata;
      if (hit(cmd, ADDR_DELAY_CTRL)) delay_ctrl <= cmd.wdata;
      if (hit(cmd, ADDR_TEMP_OFFSET)) temp_reg <= cmd.wdata;
      if (hit(cmd, ADDR_DELAY_STEP)) step_reg <= cmd.wdata;
    end
  end

  wire logic [7:0] read_mux = (cmd.addr == ADDR_PHASE_SAMPLE) ? phase_reg :
                              (cmd.addr == ADDR_READOUT) ? readout_reg :
                              (cmd.addr == ADDR_MULT_HIGH) ? mult_high :
                              (cmd.addr == ADDR_MULT_LOW) ? mult_low :
                              (cmd.addr == ADDR_LEN_HIGH) ? len_high :
                              (cmd.addr == ADDR_LEN_LOW) ? len_low :
                              (cmd.addr == ADDR_DELAY_CTRL) ? delay_ctrl :
                              (cmd.addr == ADDR_TEMP_OFFSET) ? temp_reg :
                              (cmd.addr == ADDR_DELAY_STEP) ? step_reg : UNMAPPED_READ;

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      REG_RDATA_OUT <= 8'h00;
      REG_RVALID_OUT <= 1'b0;
    end else begin
      REG_RVALID_OUT <= cmd.rd;
      if (cmd.rd) REG_RDATA_OUT <= read_mux;
    end
  end

  tof_cfg_decode u_decode (
    .phase_reg_in(phase_reg),
    .readout_reg_in(readout_reg),
    .mult_high_in(mult_high),
    .mult_low_in(mult_low),
    .len_high_in(len_high),
    .len_low_in(len_low),
    .delay_ctrl_in(delay_ctrl),
    .temp_reg_in(temp_reg),
    .step_reg_in(step_reg),
    .cfg_out(shadow_cfg)
  );

  // a mid-frame write would tear the frame, so the live set only loads on a frame start
  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      active_cfg <= '0;
    end else if (FRAME_START_IN) begin
      active_cfg <= shadow_cfg;
    end
  end

  // single-length integration timer; per-row lengths live outside this block
  wire logic single_mode = ~shadow_cfg.per_row_integration;
  wire logic last_period = (period_count == 16'h0001) || (period_count == 16'h0000);
  wire logic last_repeat = (repeat_count == 10'h001) || (repeat_count == 10'h000);

  always_ff @(posedge CORE_CLK_IN) begin
    if (RST_IN) begin
      period_count <= 16'h0000;
      repeat_count <= 10'h000;
      integrating <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (FRAME_START_IN) begin
        period_count <= shadow_cfg.length;
        repeat_count <= shadow_cfg.multiplier;
        integrating <= single_mode;
      end else if (integrating && MOD_TICK_IN) begin
        if (!last_period) begin
          period_count <= period_count - 16'h0001;
        end else if (!last_repeat) begin
          period_count <= active_cfg.length;
          repeat_count <= repeat_count - 10'h001;
        end else begin
          integrating <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  assign CFG_OUT = active_cfg;
  assign INTEGRATING_OUT = integrating;
  assign INTEGRATION_DONE_OUT = done;

  property p_cfg_hold;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      !FRAME_START_IN |=> $stable(active_cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without frame start");

  property p_cfg_load;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      FRAME_START_IN |=> active_cfg == $past(shadow_cfg);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config not loaded at frame start");

  property p_samples;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      phase_reg[SAMPLE_COUNT_LSB +: 2] == 2'h3 |-> shadow_cfg.sample_count == SAMPLES_FOUR;
  endproperty
  a_samples: assert property (p_samples) else $error("four sample code misdecoded");

  property p_gray;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      phase_reg[MOD_MODE_LSB +: 2] == 2'h3 |-> shadow_cfg.mod_mode == MOD_GRAY;
  endproperty
  a_gray: assert property (p_gray) else $error("gray mode misdecoded");

  property p_row_sum;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] == 3'h3 |-> shadow_cfg.pixel_mode == row_sum_mode;
  endproperty
  a_row_sum: assert property (p_row_sum) else $error("row sum misdecoded");

  property p_format;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      hit(cmd, ADDR_READOUT) |=> shadow_cfg.signed_format == $past(cmd.wdata[FORMAT_BIT])
        && shadow_cfg.flags_embedded == !$past(cmd.wdata[RAW_BIT]);
  endproperty
  a_format: assert property (p_format) else $error("format bits not applied");

  property p_len_write;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      hit(cmd, ADDR_LEN_LOW) |=> shadow_cfg.length[7:0] == $past(cmd.wdata);
  endproperty
  a_len_write: assert property (p_len_write) else $error("length low byte not stored");

  property p_delay;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      delay_ctrl == DELAY_OFF |-> !shadow_cfg.delay_enable;
  endproperty
  a_delay: assert property (p_delay) else $error("delay enabled while off");

  property p_unsupported;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      (temp_reg == NOT_SUPPORTED) |-> !shadow_cfg.temp_supported;
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("0xFF not flagged unsupported");

  property p_samples_one;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      phase_reg[SAMPLE_COUNT_LSB +: 2] == 2'h0 |-> shadow_cfg.sample_count == SAMPLES_ONE;
  endproperty
  a_samples_one: assert property (p_samples_one) else $error("one sample code misdecoded");

  property p_samples_two;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      phase_reg[SAMPLE_COUNT_LSB +: 2] == 2'h1 |-> shadow_cfg.sample_count == SAMPLES_TWO;
  endproperty
  a_samples_two: assert property (p_samples_two) else $error("two sample code misdecoded");

  property p_distance;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      phase_reg[MOD_MODE_LSB +: 2] == 2'h0 |-> shadow_cfg.mod_mode == MOD_DISTANCE;
  endproperty
  a_distance: assert property (p_distance) else $error("distance mode misdecoded");

  property p_full_image;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] == 3'h0 |->
        shadow_cfg.pixel_mode inside {full_imager_distance_mode, full_imager_gray_mode};
  endproperty
  a_full_image: assert property (p_full_image) else $error("full imager misdecoded");

  property p_all_sum;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] == 3'h1 |-> shadow_cfg.pixel_mode == all_pixel_sum_mode;
  endproperty
  a_all_sum: assert property (p_all_sum) else $error("all pixel sum misdecoded");

  property p_center_sum;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] == 3'h2 |-> shadow_cfg.pixel_mode == center_four_sum_mode;
  endproperty
  a_center_sum: assert property (p_center_sum) else $error("centre sum misdecoded");

  property p_binned;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] == 3'h5 |-> shadow_cfg.pixel_mode == binned_gray_mode;
  endproperty
  a_binned: assert property (p_binned) else $error("binned mode misdecoded");

  property p_pixel_reserved;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[PIXEL_MODE_LSB +: 3] inside {3'h4, 3'h6, 3'h7} |-> shadow_cfg.pixel_mode == PIXEL_BAD;
  endproperty
  a_pixel_reserved: assert property (p_pixel_reserved) else $error("reserved pixel code accepted");

  property p_raw;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      readout_reg[RAW_BIT] |-> !shadow_cfg.flags_embedded;
  endproperty
  a_raw: assert property (p_raw) else $error("flags embedded in raw format");

  property p_mult_write;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      hit(cmd, ADDR_MULT_LOW) |=> shadow_cfg.multiplier[7:0] == $past(cmd.wdata);
  endproperty
  a_mult_write: assert property (p_mult_write) else $error("multiplier low byte not stored");

  property p_len_high;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      hit(cmd, ADDR_LEN_HIGH) |=> shadow_cfg.length[15:8] == $past(cmd.wdata);
  endproperty
  a_len_high: assert property (p_len_high) else $error("length high byte not stored");

  property p_delay_manual;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      delay_ctrl == DELAY_MANUAL |-> shadow_cfg.delay_enable && !shadow_cfg.delay_bad;
  endproperty
  a_delay_manual: assert property (p_delay_manual) else $error("manual delay not applied");

  property p_temp_zero;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      temp_reg == TEMP_ZERO |-> shadow_cfg.temp_supported && shadow_cfg.temp_offset_steps == 9'h000;
  endproperty
  a_temp_zero: assert property (p_temp_zero) else $error("zero temperature offset misread");

  property p_step_center;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      step_reg == STEP_CENTER |-> shadow_cfg.step_ps == 16'(STEP_BASE_PS);
  endproperty
  a_step_center: assert property (p_step_center) else $error("centre delay step wrong");

  property p_start_timer;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      FRAME_START_IN && single_mode |=> integrating && period_count == $past(shadow_cfg.length);
  endproperty
  a_start_timer: assert property (p_start_timer) else $error("single length timer not started");

  property p_per_row_idle;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      FRAME_START_IN && shadow_cfg.per_row_integration |=> !integrating;
  endproperty
  a_per_row_idle: assert property (p_per_row_idle) else $error("timer runs in per-row frame");

  sequence s_short_start;
    FRAME_START_IN && single_mode && shadow_cfg.length == 16'h0001 && shadow_cfg.multiplier == 10'h001;
  endsequence
  property p_short_done;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      s_short_start ##1 (MOD_TICK_IN && !FRAME_START_IN) |=> done;
  endproperty
  a_short_done: assert property (p_short_done) else $error("one period integration not done");

  property p_read;
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
      cmd.rd && !cmd.wr |=> REG_RVALID_OUT && REG_RDATA_OUT == $past(read_mux);
  endproperty
  a_read: assert property (p_read) else $error("read data wrong");
endmodule

// *** tb/tof_host_model.sv ***
`timescale 1ns/1ps
module tof_host_model
  import tof_cfg_pkg::*;
(
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end
  // a request is launched after an edge and held across the next edge, which takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b0;
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
  endtask
  // read request for any address, launched like a write; the reply appears one edge later
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b1;
    addr_out <= a;
  endtask
  // released bus shows inverted values so a stale address is never mistaken for a live one
  task automatic idle();
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~addr_out;
    wdata_out <= ~wdata_out;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench
  import tof_cfg_pkg::*;
;
  logic CORE_CLK_IN, RST_IN, REG_WR_IN, REG_RD_IN, REG_RVALID_OUT, FRAME_START_IN, MOD_TICK_IN;
  logic INTEGRATING_OUT, INTEGRATION_DONE_OUT, fs_d;
  logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT;
  acq_config_type CFG_OUT, prev;
  logic [7:0] rq[$];
  acq_config_type cq[$];
  logic [7:0] v[9];
  int n_fail = 0;
  int cmp_count = 0;
  bit hung = 1'b0;
  logic [31:0] rnd;
  const logic [7:0] addrs[9] = '{ADDR_PHASE_SAMPLE, ADDR_READOUT, ADDR_MULT_HIGH, ADDR_MULT_LOW,
    ADDR_LEN_HIGH, ADDR_LEN_LOW, ADDR_DELAY_CTRL, ADDR_TEMP_OFFSET, ADDR_DELAY_STEP};
  const logic [7:0] rsts[9] = '{RST_PHASE_SAMPLE, RST_READOUT, RST_MULT_HIGH, RST_MULT_LOW,
    RST_LEN_HIGH, RST_LEN_LOW, RST_DELAY_CTRL, RST_TEMP_OFFSET, RST_DELAY_STEP};
  const logic [7:0] dctl[4] = '{DELAY_OFF, DELAY_MANUAL, 8'h00, NOT_SUPPORTED};

  tof_host_model i_host (.clk_in(CORE_CLK_IN), .wr_out(REG_WR_IN), .rd_out(REG_RD_IN),
    .addr_out(REG_ADDR_IN), .wdata_out(REG_WDATA_IN));
  tof_acquisition_config_regs i_dut (.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT), .FRAME_START_IN(FRAME_START_IN),
    .MOD_TICK_IN(MOD_TICK_IN), .CFG_OUT(CFG_OUT), .INTEGRATING_OUT(INTEGRATING_OUT),
    .INTEGRATION_DONE_OUT(INTEGRATION_DONE_OUT));

  initial begin
    CORE_CLK_IN = 1'b0;
    forever #50 CORE_CLK_IN = ~CORE_CLK_IN;
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%0h expected=%0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  function automatic acq_config_type exp_cfg(input logic [7:0] r[9]);
    acq_config_type c;
    c = '0;
    case (r[0][5:4])
      2'b00: c.sample_count = SAMPLES_ONE;
      2'b01: c.sample_count = SAMPLES_TWO;
      2'b11: c.sample_count = SAMPLES_FOUR;
      default: c.sample_count = SAMPLES_BAD;
    endcase
    c.mod_mode = (r[0][7:6] == 2'b00) ? MOD_DISTANCE : (r[0][7:6] == 2'b11) ? MOD_GRAY : MOD_BAD;
    case (r[1][4:2])
      3'h0: c.pixel_mode = (r[0][7:6] == 2'b11) ? full_imager_gray_mode : full_imager_distance_mode;
      3'h1: c.pixel_mode = all_pixel_sum_mode;
      3'h2: c.pixel_mode = center_four_sum_mode;
      3'h3: c.pixel_mode = row_sum_mode;
      3'h5: c.pixel_mode = binned_gray_mode;
      default: c.pixel_mode = PIXEL_BAD;
    endcase
    c.signed_format = r[1][5];
    c.flags_embedded = ~r[1][6];
    c.per_row_integration = (r[0][3:2] == 2'b10);
    c.int_sel_bad = r[0][2];
    c.multiplier = {r[2][1:0], r[3]};
    c.length = {r[4], r[5]};
    c.delay_enable = (r[6] == DELAY_MANUAL);
    c.delay_bad = (r[6] != DELAY_OFF) && (r[6] != DELAY_MANUAL);
    c.temp_supported = (r[7] != NOT_SUPPORTED);
    c.temp_offset_steps = 9'(int'(r[7]) - 127);
    c.step_supported = (r[8] != NOT_SUPPORTED);
    c.step_ps = 16'((int'(r[8]) - 128) * STEP_UNIT_PS + STEP_BASE_PS);
    return c;
  endfunction

  task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    i_host.rd(a);
  endtask

  // counts integrating cycles up to the done pulse; per-row frames must never start the timer
  task automatic frame(input acq_config_type e, input int ticks);
    int n;
    bit done;
    n = 0;
    done = 0;
    @(posedge CORE_CLK_IN);
    FRAME_START_IN <= 1'b1;
    MOD_TICK_IN <= 1'b1;
    @(posedge CORE_CLK_IN);
    FRAME_START_IN <= 1'b0;
    cq.push_back(e);
    for (int i = 0; i < ((ticks == 0) ? 8 : 300) && !done; i++) begin
      @(negedge CORE_CLK_IN);
      if (INTEGRATION_DONE_OUT === 1'b1) done = 1;
      else if (INTEGRATING_OUT === 1'b1) n++;
    end
    if (ticks != 0 && !done) begin
      n_fail++;
      hung = 1'b1;
    end
    check(n, ticks);
    check(done, ticks != 0);
    @(posedge CORE_CLK_IN);
    MOD_TICK_IN <= 1'b0;
  endtask

  always @(posedge CORE_CLK_IN) fs_d <= FRAME_START_IN;

  always @(negedge CORE_CLK_IN) begin
    if (REG_RVALID_OUT === 1'b1) begin
      if (rq.size() == 0) check(1, 0);
      else check(REG_RDATA_OUT, rq.pop_front());
    end
    if (fs_d === 1'b1 && cq.size() > 0) check(CFG_OUT, cq.pop_front());
  end

  initial begin
    RST_IN = 1'b1;
    FRAME_START_IN = 1'b0;
    MOD_TICK_IN = 1'b0;
    fs_d = 1'b0;
    rnd = $urandom(10);
    repeat (6) @(posedge CORE_CLK_IN);
    RST_IN <= 1'b0;
    @(negedge CORE_CLK_IN);
    check(CFG_OUT, 0);
    check(INTEGRATING_OUT, 0);
    v = rsts;
    prev = exp_cfg(v);
    frame(prev, 1);
    for (int j = 0; j < 9; j++) rd_exp(addrs[j], rsts[j]);
    rd_exp(8'h93, UNMAPPED_READ);
    i_host.idle();
    for (int k = 0; k < 8 && !hung; k++) begin
      rnd = $urandom;
      v[0] = {2'(k), 2'(k >> 1), 1'(k), 1'(k >> 2), rnd[1:0]};
      v[1] = {rnd[2], 1'(k), 1'(k >> 1), 3'(k), rnd[4:3]};
      v[2] = rnd[15:8] & 8'hFC;
      v[3] = 8'(k + 1);
      v[4] = 8'h00;
      v[5] = 8'(k + 1);
      v[6] = dctl[k % 4];
      v[7] = (k == 1) ? NOT_SUPPORTED : (k == 3) ? TEMP_ZERO : rnd[23:16];
      v[8] = (k == 2) ? NOT_SUPPORTED : (k == 4) ? STEP_CENTER : rnd[31:24];
      for (int j = 0; j < 9; j++) i_host.wr(addrs[j], v[j]);
      for (int j = 0; j < 9; j++) rd_exp(addrs[j], v[j]);
      i_host.idle();
      @(negedge CORE_CLK_IN);
      check(CFG_OUT, prev);
      prev = exp_cfg(v);
      frame(prev, (v[0][3:2] == 2'b10) ? 0 : (k + 1) * (k + 1));
    end
    repeat (3) @(negedge CORE_CLK_IN);
    check(rq.size() + cq.size(), 0);
    finish_test();
  end
endmodule
